// ### rtl/uart_irq_id_line_modem_ctrl.sv
// Interrupt identification, line format and modem control of a serial port
// Assumes external FIFOs, shifters and baud generator on the same clock
`timescale 1ns/1ps
`include "uart_irq_regs.svh"
module uart_irq_id_line_modem_ctrl
   import uart_irq_pkg::*;
#(
   parameter int DEPTH = 16,                      // Receive FIFO depth
   parameter int LVL_W = $clog2(DEPTH + 1)        // Fill level width
)
(
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   input  wire logic             ce,              // Freezes all state when low
   input  wire logic [2:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   input  wire logic [7:0]       rx_data_in,      // Head of receive path
   input  wire logic [LVL_W-1:0] rx_level,        // Receive FIFO fill level
   input  wire logic             rx_push,         // Character entered FIFO
   input  wire logic             rx_pop,          // Character left FIFO
   input  wire logic             rx_char_valid,   // Received frame complete
   input  wire logic [7:0]       rx_char,         // Received data bits
   input  wire logic             rx_parity_bit,   // Sampled parity bit
   input  wire logic             rx_stop_bit,     // Sampled first stop bit
   input  wire logic             rx_overrun,      // Overrun event pulse
   input  wire logic             rx_break,        // Break event pulse
   input  wire logic             rx_fifo_err,     // Error held in FIFO
   input  wire logic             thr_empty,       // Holding register empty
   input  wire logic             tx_empty,        // Holding and shifter empty
   input  wire logic [7:0]       tx_char,         // Character being framed
   input  wire logic             tx_serial_in,    // Shifter serial output
   input  wire logic             baud_tick16,     // Sixteen per bit time
   input  wire modem_in_t        modem_in,
   output logic                  txd_out,
   output logic                  terminal_ready_n_out,
   output logic                  send_request_n_out,
   output logic                  irq_out,
   output logic                  irq_oe_n,
   output line_fmt_t             fmt_out,
   output logic      [2:0]       stop_half_bits,
   output logic                  tx_parity_out,
   output logic      [15:0]      divisor,
   output logic                  fifo_mode,
   output logic      [4:0]       rx_trigger,
   output logic                  rbr_rd,
   output logic                  thr_wr,
   output logic      [7:0]       thr_data,
   output logic                  rx_fifo_clr,
   output logic                  tx_fifo_clr
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (DEPTH < 14 || DEPTH > 31)
   begin : g_bad_depth
      $error("DEPTH must lie between 14 and 31");
   end
   // ----------------------------------------
   // Register state
   // ----------------------------------------
   line_fmt_t  fmt_ff;                 // Line format control
   logic [7:0] modem_ctl_ff;           // Modem line control
   logic [3:0] irq_en_ff;              // Source enables
   logic [7:0] scr_ff;                 // Scratch byte
   logic [7:0] dll_ff;                 // Divisor low
   logic [7:0] dlm_ff;                 // Divisor high
   logic       fifo_en_ff;             // FIFO mode
   logic [1:0] trig_sel_ff;            // Trigger select
   err_t       err_ff;                 // Sticky line errors
   logic [3:0] delta_ff;               // Sticky modem changes
   modem_in_t  modem_prev_ff;          // Last sampled modem inputs
   logic       thre_ff;                // Holding empty pending
   logic       thr_empty_prev_ff;      // Edge finder for empty
   logic       tmo_ff;                 // Character timeout pending
   logic [9:0] tmo_cnt_ff;             // Ticks since last FIFO move
   logic [7:0] rdata_ff;
   logic       thr_wr_ff;
   logic [7:0] thr_data_ff;
   logic       rx_clr_ff;
   logic       tx_clr_ff;
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   logic wr_c, rd_c;
   assign wr_c = ce & reg_wr;
   assign rd_c = ce & reg_rd;
   logic wr_data, wr_irq_en, wr_fifo_setup, wr_fmt, wr_modem_ctl, wr_scr, wr_dll, wr_dlm;
   logic rd_ident, rd_line_stat, rd_modem_stat;
   // Offsets 0 and 1 switch between data path and divisor
   assign wr_data       = wr_c & reg_addr == `OFS_DATA & ~fmt_ff.divisor_latch_select;
   assign wr_dll        = wr_c & reg_addr == `OFS_DATA & fmt_ff.divisor_latch_select;
   assign wr_irq_en     = wr_c & reg_addr == `OFS_IRQ_ENABLE & ~fmt_ff.divisor_latch_select;
   assign wr_dlm        = wr_c & reg_addr == `OFS_IRQ_ENABLE & fmt_ff.divisor_latch_select;
   assign wr_fifo_setup = wr_c & reg_addr == `OFS_IDENT;
   assign wr_fmt        = wr_c & reg_addr == `OFS_LINE_FMT;
   assign wr_modem_ctl  = wr_c & reg_addr == `OFS_MODEM_CTL;
   assign wr_scr        = wr_c & reg_addr == `OFS_SCRATCH;
   assign rbr_rd        = rd_c & reg_addr == `OFS_DATA & ~fmt_ff.divisor_latch_select;
   assign rd_ident      = rd_c & reg_addr == `OFS_IDENT;
   assign rd_line_stat  = rd_c & reg_addr == `OFS_LINE_STAT;
   assign rd_modem_stat = rd_c & reg_addr == `OFS_MODEM_STAT;
   // ----------------------------------------
   // Format helpers
   // ----------------------------------------
   // Parity over the active data bits only
   function automatic logic par_of(input logic [7:0] d, input line_fmt_t f);
      logic [7:0] m;
      m = 8'hFF >> (2'd3 - f.wl);
      // Even makes ones count even; stick gives inverse of even select
      return f.stick ? ~f.even : (^(d & m)) ^ ~f.even;
   endfunction
   // Long stop setting gives 1.5 stops only with five bit words
   assign stop_half_bits = ~fmt_ff.stop_long ? 3'd2 :
                           (fmt_ff.wl == 2'd0 ? 3'd3 : 3'd4);
   assign fmt_out        = fmt_ff;
   // Parity bit placed by the shifter after the last data bit
   assign tx_parity_out  = par_of(tx_char, fmt_ff);
   assign divisor        = {dlm_ff, dll_ff};
   assign fifo_mode      = fifo_en_ff;
   // Serial output forced to spacing while break is held
   assign txd_out        = fmt_ff.brk ? 1'b0 : tx_serial_in;
   assign terminal_ready_n_out = ~modem_ctl_ff[0];
   assign send_request_n_out   = ~modem_ctl_ff[1];
   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Software written configuration
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         fmt_ff       <= line_fmt_t'(`RST_BYTE);
         modem_ctl_ff <= `RST_BYTE;
         irq_en_ff    <= 4'h0;
         scr_ff <= `RST_BYTE;
         {dlm_ff, dll_ff} <= `RST_DIVISOR;
      end
      else
      begin
         if (wr_fmt) fmt_ff <= line_fmt_t'(reg_wdata);
         // Upper modem bits hold no function here
         if (wr_modem_ctl) modem_ctl_ff <= {3'b000, reg_wdata[4:0]};
         if (wr_irq_en) irq_en_ff <= reg_wdata[3:0];
         if (wr_scr) scr_ff <= reg_wdata;
         if (wr_dll) dll_ff <= reg_wdata;
         if (wr_dlm) dlm_ff <= reg_wdata;
      end
   end
   // FIFO setup; trigger select only takes effect with enable set, the clear bits act in either mode
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         fifo_en_ff  <= 1'b0;
         trig_sel_ff <= 2'b00;
         rx_clr_ff   <= 1'b0;
         tx_clr_ff   <= 1'b0;
      end
      else if (ce)
      begin
         rx_clr_ff <= 1'b0;
         tx_clr_ff <= 1'b0;
         if (wr_fifo_setup)
         begin
            fifo_en_ff <= reg_wdata[`FIFO_EN_BIT];
            // A mode change empties both FIFOs
            rx_clr_ff  <= reg_wdata[`FIFO_RXCLR_BIT] |
                          (reg_wdata[`FIFO_EN_BIT] != fifo_en_ff);
            tx_clr_ff  <= reg_wdata[`FIFO_TXCLR_BIT] |
                          (reg_wdata[`FIFO_EN_BIT] != fifo_en_ff);
            if (reg_wdata[`FIFO_EN_BIT])
               trig_sel_ff <= reg_wdata[7:6];
         end
      end
   end
   assign rx_fifo_clr = rx_clr_ff;
   assign tx_fifo_clr = tx_clr_ff;
   // Trigger level decode
   always_comb
   begin
      unique case (trig_sel_ff)
         2'b00: rx_trigger = `TRIG_1;
         2'b01: rx_trigger = `TRIG_4;
         2'b10: rx_trigger = `TRIG_8;
         2'b11: rx_trigger = `TRIG_14;
      endcase
   end
   // Holding register write hands the byte to the transmit path
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         thr_wr_ff   <= 1'b0;
         thr_data_ff <= `RST_BYTE;
      end
      else if (ce)
      begin
         thr_wr_ff <= wr_data;
         if (wr_data) thr_data_ff <= reg_wdata;
      end
   end
   assign thr_wr   = thr_wr_ff;
   assign thr_data = thr_data_ff;
   // ----------------------------------------
   // Interrupt sources
   // ----------------------------------------
   err_t err_set;
   logic rx_par_bad;
   assign rx_par_bad = fmt_ff.par_en &
                       (rx_parity_bit != par_of(rx_char, fmt_ff));
   // Only the first stop bit is judged for framing
   assign err_set = '{brk: rx_break,
                      fe:  rx_char_valid & ~rx_stop_bit,
                      pe:  rx_char_valid & rx_par_bad,
                      oe:  rx_overrun};
   // Line errors: new events win over the status read clear
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         err_ff <= '0;
      else if (ce)
         err_ff <= (rd_line_stat ? '0 : err_ff) | err_set;
   end
   // Modem change flags; ring reports only its trailing edge
   logic [3:0] mdm_set;
   assign mdm_set = {modem_in.dcd_n ^ modem_prev_ff.dcd_n,
                     modem_in.ri_n & ~modem_prev_ff.ri_n,
                     modem_in.dsr_n ^ modem_prev_ff.dsr_n,
                     modem_in.cts_n ^ modem_prev_ff.cts_n};
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         modem_prev_ff <= '1;
         delta_ff      <= 4'h0;
      end
      else if (ce)
      begin
         modem_prev_ff <= modem_in;
         delta_ff      <= (rd_modem_stat ? 4'h0 : delta_ff) | mdm_set;
      end
   end
   // Identification value, assembled live
   logic [7:0] ident_now;
   logic       p_line, p_rda, p_tmo, p_thr, p_modem;
   logic [3:0] id_code;
   // Holding empty: set on empty edge, cleared by write or by reading it
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         thr_empty_prev_ff <= 1'b1;
         thre_ff           <= 1'b0;
      end
      else if (ce)
      begin
         thr_empty_prev_ff <= thr_empty;
         if (thr_empty & ~thr_empty_prev_ff)
            thre_ff <= 1'b1;
         else if (wr_data | (rd_ident & id_code == `ID_THRE))
            thre_ff <= 1'b0;
      end
   end
   // Timeout: four character times of the current format, in half bits
   logic [4:0] half_bits;
   logic [9:0] tmo_limit;
   assign half_bits = 5'd12 + {2'b00, fmt_ff.wl, 1'b0} +
                      {3'b000, fmt_ff.par_en, 1'b0} + {2'b00, stop_half_bits};
   assign tmo_limit = 10'(half_bits * (`TICKS_HALF_BIT * `TIMEOUT_CHARS));
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         tmo_cnt_ff <= 10'h000;
         tmo_ff     <= 1'b0;
      end
      else if (ce)
      begin
         // Any movement or an empty FIFO restarts the count
         if (rx_push | rx_pop | rx_level == '0 | ~fifo_en_ff)
            tmo_cnt_ff <= 10'h000;
         else if (baud_tick16 & tmo_cnt_ff != tmo_limit)
            tmo_cnt_ff <= tmo_cnt_ff + 10'h001;
         // A saturated count must not outvote the clear of a data read
         if (fifo_en_ff & rx_level != '0 & ~(rx_push | rx_pop) & tmo_cnt_ff == tmo_limit)
            tmo_ff <= 1'b1;
         else if (rbr_rd | ~fifo_en_ff)
            tmo_ff <= 1'b0;
      end
   end
   // ----------------------------------------
   // Priority and identification
   // ----------------------------------------
   logic [LVL_W-1:0] trig_lvl;
   assign trig_lvl = LVL_W'(rx_trigger);
   assign p_line  = irq_en_ff[2] & (|err_ff);
   // Data pending falls away as soon as the level drops under trigger in FIFO mode, or to zero outside it
   assign p_rda   = irq_en_ff[0] & (fifo_en_ff ? rx_level >= trig_lvl
                                               : rx_level != '0);
   assign p_tmo   = irq_en_ff[0] & tmo_ff;
   assign p_thr   = irq_en_ff[1] & thre_ff;
   assign p_modem = irq_en_ff[3] & (|delta_ff);
   always_comb
   begin
      if (p_line)       id_code = `ID_LINE;
      else if (p_rda)   id_code = `ID_RXDATA;
      else if (p_tmo)   id_code = `ID_TIMEOUT;
      else if (p_thr)   id_code = `ID_THRE;
      else if (p_modem) id_code = `ID_MODEM;
      else              id_code = `ID_NONE;
   end
   assign ident_now = {{2{fifo_en_ff}}, 2'b00, id_code};
   // Interrupt pin tri-stated unless the output gate bit is set
   assign irq_out  = ~id_code[0];
   assign irq_oe_n = ~modem_ctl_ff[`MODEM_CTL_GATE_BIT];
   // ----------------------------------------
   // Read data
   // ----------------------------------------
   // Captured at the strobe, so the reported value cannot move mid-access
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rdata_ff <= `RST_BYTE;
      else if (rd_c)
      begin
         unique case (reg_addr)
            `OFS_DATA:       rdata_ff <= fmt_ff.divisor_latch_select ? dll_ff : rx_data_in;
            `OFS_IRQ_ENABLE: rdata_ff <= fmt_ff.divisor_latch_select ? dlm_ff : {4'h0, irq_en_ff};
            `OFS_IDENT:      rdata_ff <= ident_now;
            `OFS_LINE_FMT:   rdata_ff <= fmt_ff;
            `OFS_MODEM_CTL:  rdata_ff <= modem_ctl_ff;
            `OFS_LINE_STAT:  rdata_ff <= {fifo_en_ff & rx_fifo_err, tx_empty,
                                          thr_empty, err_ff, rx_level != '0};
            `OFS_MODEM_STAT: rdata_ff <= {~modem_in, delta_ff};
            `OFS_SCRATCH:    rdata_ff <= scr_ff;
         endcase
      end
   end
   assign reg_rdata = rdata_ff;
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_ident_rd;
      rd_ident;
   endsequence
   sequence s_line_stat_rd;
      rd_line_stat ##0 (err_set == '0);
   endsequence
   sequence s_thr_wr;
      wr_data ##0 !(thr_empty & ~thr_empty_prev_ff);
   endsequence
   AST_IDENT_SNAPSHOT: assert property (s_ident_rd |=> reg_rdata == $past(ident_now))
      else $error("identification read not the value at the strobe");
   AST_PRIO_LINE: assert property (p_line |-> id_code == `ID_LINE)
      else $error("line status not reported first");
   AST_PENDING_BIT: assert property (ident_now[0] == !(p_line | p_rda | p_tmo | p_thr | p_modem))
      else $error("pending bit wrong");
   AST_CODE_DATA: assert property (!p_line && p_rda |-> ident_now[2:1] == 2'b10 && !ident_now[3])
      else $error("received data code wrong");
   AST_TMO_MODE: assert property (!fifo_en_ff |-> !ident_now[3])
      else $error("timeout bit outside FIFO mode");
   AST_TOP_BITS: assert property (ident_now[5:4] == 2'b00 && ident_now[7:6] == {2{fifo_en_ff}})
      else $error("upper identification bits wrong");
   AST_LINE_STAT_CLEAR: assert property (s_line_stat_rd |=> err_ff == '0)
      else $error("line errors survive status read");
   AST_THRE_CLEAR: assert property (s_thr_wr |=> !thre_ff)
      else $error("holding empty not cleared by write");
   AST_MODEM_DELTA: assert property (ce && modem_in.cts_n != modem_prev_ff.cts_n |=> delta_ff[0] [*2])
      else $error("modem change not held");
   AST_STICK_PAR: assert property (fmt_ff.stick |-> tx_parity_out == !fmt_ff.even)
      else $error("stick parity value wrong");
   AST_BREAK_LOW: assert property (fmt_ff.brk |-> !txd_out)
      else $error("break not forcing spacing");
   AST_DIVISOR_WR: assert property (wr_dll |=> divisor[7:0] == $past(reg_wdata) && !thr_wr)
      else $error("divisor write misrouted");
   AST_IRQ_GATE: assert property (irq_oe_n == !modem_ctl_ff[3] && send_request_n_out == !modem_ctl_ff[1])
      else $error("gate or send request polarity wrong");
endmodule

// ### rtl/uart_irq_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design module
`ifndef UART_IRQ_REGS_SVH
`define UART_IRQ_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_DATA        3'h0
`define OFS_IRQ_ENABLE  3'h1
`define OFS_IDENT       3'h2
`define OFS_LINE_FMT    3'h3
`define OFS_MODEM_CTL   3'h4
`define OFS_LINE_STAT   3'h5
`define OFS_MODEM_STAT  3'h6
`define OFS_SCRATCH     3'h7
// ----------------------------------------
// Identification codes, low nibble
// ----------------------------------------
`define ID_NONE         4'h1
`define ID_LINE         4'h6
`define ID_RXDATA       4'h4
`define ID_TIMEOUT      4'hC
`define ID_THRE         4'h2
`define ID_MODEM        4'h0
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FIFO_EN_BIT     0
`define FIFO_RXCLR_BIT  1
`define FIFO_TXCLR_BIT  2
`define MODEM_CTL_GATE_BIT 3
`define RST_BYTE        8'h00
`define RST_DIVISOR     16'h0001
// ----------------------------------------
// Trigger levels and timing counts
// ----------------------------------------
`define TRIG_1          5'h01
`define TRIG_4          5'h04
`define TRIG_8          5'h08
`define TRIG_14         5'h0E
`define TICKS_HALF_BIT  8
`define TIMEOUT_CHARS   4
`endif

// ### rtl/uart_irq_pkg.sv
// Types shared by the serial port control block
// Assumes the register header is on the include path
package uart_irq_pkg;
   // Line format control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic       divisor_latch_select; // Divisor latch select
      logic       brk;        // Force spacing on the line
      logic       stick;      // Fixed parity
      logic       even;       // Even parity select
      logic       par_en;     // Parity present
      logic       stop_long;  // Long stop setting
      logic [1:0] wl;         // Word length minus five
   } line_fmt_t;
   // Receive error flags feeding the line status interrupt
   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
      logic oe;
   } err_t;
   // Modem inputs, active low as on the pins
   typedef struct packed {
      logic dcd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } modem_in_t;
endpackage

// ### verification/modem_peer.sv
// Modem side model: answers the ready and request lines of the port
// Assumes one system clock and the active-low modem pins of the block
`timescale 1ns/1ps
module modem_peer
   import uart_irq_pkg::*;
#(
   parameter int LAG = 4                    // Answer delay in clock cycles
)
(
   input  wire logic clk_sys,
   input  wire logic terminal_ready_n_out,
   input  wire logic send_request_n_out,
   output modem_in_t modem_in
);
   // ----------------------------------------
   // Answer delay line
   // ----------------------------------------
   logic [1:0] echo_ff [LAG] = '{default: 2'h3};  // Idle high, as pulled up

   // A real modem answers late, so both echoes lag the requests
   always @(posedge clk_sys)
   begin
      echo_ff[0] <= {terminal_ready_n_out, send_request_n_out};
      for (int i = 1; i < LAG; i++)
         echo_ff[i] <= echo_ff[i-1];
   end

   // Carrier and ring stay inactive; set ready and clear to send echo
   assign modem_in = '{dcd_n: 1'h1, ri_n: 1'h1, dsr_n: echo_ff[LAG-1][1], cts_n: echo_ff[LAG-1][0]};
endmodule

// ### verification/tb_uart_irq_id_line_modem_ctrl.sv
// Bench for the identification, line format and modem control block
// Assumes a modem peer model on the modem pins and a 200 MHz clock
`timescale 1ns/1ps
module tb_uart_irq_id_line_modem_ctrl
   import uart_irq_pkg::*;
();
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic        clk_sys = 1'h0, rstn = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, thr_empty = 1'h0;
   logic        rx_overrun = 1'h0, rx_break = 1'h0, rx_char_valid = 1'h0, rx_stop_bit = 1'h1;
   logic        tx_serial_in = 1'h1, baud_tick16 = 1'h0;
   logic [2:0]  reg_addr = 3'h0, stop_half_bits;
   logic [7:0]  reg_wdata = 8'h00, tx_char = 8'h03, rdata, rdv, thr_data;
   logic [4:0]  rx_level = 5'h00, rx_trigger;
   logic        fifo_mode, rbr_rd, rx_fifo_clr, tx_fifo_clr;   // Data reads also pop the modelled FIFO
   logic [15:0] divisor;
   logic        txd_out, terminal_ready_n_out, send_request_n_out, irq_out, irq_oe_n, tx_parity_out, thr_wr;
   line_fmt_t   fmt_out;
   modem_in_t   modem_in;
   int          miscompares = 0, total_checks = 0, cycles = 0;

   uart_irq_id_line_modem_ctrl uut (.clk_sys, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata(rdata), .rx_data_in(8'hA5), .rx_level, .rx_push(1'h0), .rx_pop(rbr_rd), .rx_char_valid,
      .rx_char(tx_char), .rx_parity_bit(tx_parity_out), .rx_stop_bit, .rx_overrun, .rx_break,
      .rx_fifo_err(1'h0), .thr_empty, .tx_empty(thr_empty), .tx_char, .tx_serial_in, .baud_tick16,
      .modem_in, .txd_out, .terminal_ready_n_out, .send_request_n_out, .irq_out, .irq_oe_n, .fmt_out,
      .stop_half_bits, .tx_parity_out, .divisor, .fifo_mode, .rx_trigger, .rbr_rd, .thr_wr,
      .thr_data, .rx_fifo_clr, .tx_fifo_clr);
   modem_peer #(.LAG(4)) peer (.clk_sys, .terminal_ready_n_out, .send_request_n_out, .modem_in);

   // ----------------------------------------
   // Clock, tick source and hang guard
   // ----------------------------------------
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cycles++;
      baud_tick16 <= ~baud_tick16;
      if (cycles == 4000)
      begin
         miscompares++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One-cycle write; outputs settle just after the closing edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      #1;
   endtask
   // Read data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 rdv = rdata;
   endtask
   task automatic end_sim();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge clk_sys);
      rstn <= 1'h1;
      rd(3'h2);
      chk("ident", 16'(rdv), 16'h0001);
      chk("ready pin", 16'(terminal_ready_n_out), 16'h0001);
      wr(3'h4, 8'h0B);
      chk("ready pin", 16'(terminal_ready_n_out), 16'h0000);
      chk("request pin", 16'(send_request_n_out), 16'h0000);
      chk("irq enable", 16'(irq_oe_n), 16'h0000);
      repeat (8) @(posedge clk_sys);
      chk("irq masked", 16'(irq_out), 16'h0000);
      rd(3'h6);
      chk("modem stat", 16'(rdv), 16'h0033);
      wr(3'h1, 8'h0F);
      @(posedge clk_sys) thr_empty <= 1'h1;
      rx_stop_bit <= 1'h0;
      // Overrun, break, then a frame with a bad stop bit
      for (int k = 0; k < 3; k++)
      begin
         @(posedge clk_sys) {rx_overrun, rx_break, rx_char_valid} <= 3'h4 >> k;
         @(posedge clk_sys) {rx_overrun, rx_break, rx_char_valid} <= 3'h0;
         rd(3'h2);
         chk("line first", 16'(rdv), 16'h0006);
         chk("irq pin", 16'(irq_out), 16'h0001);
         rd(3'h5);
      end
      rx_stop_bit <= 1'h1;
      rd(3'h2);
      chk("holding empty", 16'(rdv), 16'h0002);
      rd(3'h2);
      chk("cleared by read", 16'(rdv), 16'h0001);
      @(posedge clk_sys) thr_empty <= 1'h0;
      @(posedge clk_sys) thr_empty <= 1'h1;
      wr(3'h0, 8'h5A);
      chk("holding write", 16'(thr_wr), 16'h0001);
      chk("holding data", 16'(thr_data), 16'h005A);
      rd(3'h2);
      chk("cleared by write", 16'(rdv), 16'h0001);
      wr(3'h4, 8'h08);
      repeat (8) @(posedge clk_sys);
      rd(3'h2);
      chk("modem last", 16'(rdv), 16'h0000);
      rd(3'h6);
      wr(3'h2, 8'h01);
      chk("fifo on", 16'({fifo_mode, rx_fifo_clr, tx_fifo_clr}), 16'h0007);
      rd(3'h2);
      chk("fifo mode", 16'(rdv), 16'h00C1);
      @(posedge clk_sys) rx_level <= 5'h01;
      repeat (2) @(posedge clk_sys);
      rd(3'h2);
      chk("data ready", 16'(rdv), 16'h00C4);
      @(posedge clk_sys) rx_level <= 5'h00;
      repeat (2) @(posedge clk_sys);
      rd(3'h2);
      chk("below trigger", 16'(rdv), 16'h00C1);
      // One byte under a trigger of 14 stays quiet until four characters pass
      wr(3'h2, 8'hC1);
      chk("trigger", 16'(rx_trigger), 16'h000E);
      @(posedge clk_sys) rx_level <= 5'h01;
      repeat (1000) @(posedge clk_sys);
      rd(3'h2);
      chk("timeout", 16'(rdv), 16'h00CC);
      rd(3'h0);
      rd(3'h2);
      chk("timeout read", 16'(rdv), 16'h00C1);
      @(posedge clk_sys) rx_level <= 5'h00;
      wr(3'h2, 8'h00);
      rd(3'h2);
      chk("plain mode", 16'(rdv), 16'h0001);
      wr(3'h3, 8'h44);
      chk("break", 16'(txd_out), 16'h0000);
      // Every word length with the long stop setting
      for (int i = 0; i < 4; i++)
      begin
         wr(3'h3, 8'h04 | 8'(i));
         chk("stop", 16'(stop_half_bits), (i == 0) ? 16'h0003 : 16'h0004);
         chk("word length", 16'(fmt_out.wl), 16'(i));
         // Odd, even, then fixed parity on two set data bits
         wr(3'h3, 8'h0B | 8'(i << 4));
         chk("parity", 16'(tx_parity_out), 16'(!i[0]));
      end
      chk("line free", 16'(txd_out), 16'h0001);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      chk("divisor", divisor, 16'h1234);
      wr(3'h3, 8'h03);
      rd(3'h0);
      chk("rx head", 16'(rdv), 16'h00A5);
      rd(3'h1);
      chk("enables", 16'(rdv), 16'h000F);
      end_sim();
   end
endmodule
